// file: design/limit_comparator.sv
`timescale 1ns/1ps
module limit_comparator
	import temp_cfg_pkg::*;
#(
	parameter bit TRIP_BELOW = 1'b0,
	parameter int W          = TEMP_W
) (
	input  logic                 i_clk,
	input  logic                 i_rst_n,
	input  logic                 i_sample,
	input  logic signed [W-1:0]  i_temp,
	input  logic signed [W-1:0]  i_limit,
	input  logic [HYST_W-1:0]    i_hyst,
	output logic                 o_trip
);

	// One extra bit so limit minus hysteresis never wraps
	logic signed [W:0] temp_x;
	logic signed [W:0] lim_x;
	logic signed [W:0] lim_h;
	logic              set_c;
	logic              clr_c;
	logic              trip_q;

	assign temp_x = {i_temp[W-1], i_temp};
	assign lim_x  = {i_limit[W-1], i_limit};
	assign lim_h  = lim_x - $signed({{(W+1-HYST_W){1'b0}}, i_hyst});

	// Hysteresis only on the falling side
	assign set_c = TRIP_BELOW ? (temp_x < lim_h) : (temp_x > lim_x);
	assign clr_c = TRIP_BELOW ? (temp_x >= lim_x) : (temp_x < lim_h);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			trip_q <= 1'b0;
		end else if (i_sample) begin
			if (set_c) begin
				trip_q <= 1'b1;
			end else if (clr_c) begin
				trip_q <= 1'b0;
			end
		end
	end

	assign o_trip = trip_q;

endmodule

// file: design/temp_cfg_pkg.sv
package temp_cfg_pkg;

	// Register selection
	localparam logic [7:0] PTR_RESET     = 8'h00;
	localparam logic [7:0] CFG_PTR       = 8'h01;
	localparam int         REG_W         = 16;

	// Field positions within the configuration word
	localparam int CFG_RSVD_MSB  = 15;
	localparam int CFG_RSVD_LSB  = 11;
	localparam int CFG_HYST_MSB  = 10;
	localparam int CFG_HYST_LSB  = 9;
	localparam int CFG_HALT_BIT  = 8;
	localparam int CFG_CLCK_BIT  = 7;
	localparam int CFG_WLCK_BIT  = 6;
	localparam int CFG_REL_BIT   = 5;
	localparam int CFG_STS_BIT   = 4;
	localparam int CFG_OEN_BIT   = 3;
	localparam int CFG_CRIT_BIT  = 2;
	localparam int CFG_POL_BIT   = 1;
	localparam int CFG_MODE_BIT  = 0;

	localparam logic [15:0] CFG_RESET = 16'h0000;

	// Temperature in 0.125 degree steps, two's complement
	localparam int TEMP_W        = 13;
	localparam int TEMP_LSB_MC   = 125;
	localparam int HYST_1P5_MC   = 1500;
	localparam int HYST_3P0_MC   = 3000;
	localparam int HYST_6P0_MC   = 6000;
	localparam int HYST_W        = 6;
	localparam logic [HYST_W-1:0] HYST_1P5_STEPS = HYST_W'(HYST_1P5_MC / TEMP_LSB_MC);
	localparam logic [HYST_W-1:0] HYST_3P0_STEPS = HYST_W'(HYST_3P0_MC / TEMP_LSB_MC);
	localparam logic [HYST_W-1:0] HYST_6P0_STEPS = HYST_W'(HYST_6P0_MC / TEMP_LSB_MC);

	// Limit comparator indices
	localparam int LIM_UPPER = 0;
	localparam int LIM_LOWER = 1;
	localparam int LIM_CRIT  = 2;
	localparam int LIM_N     = 3;

	typedef enum logic [1:0] {
		HYST_NONE = 2'b00,
		HYST_1P5  = 2'b01,
		HYST_3P0  = 2'b10,
		HYST_6P0  = 2'b11
	} hyst_sel_t;

	typedef struct packed {
		logic [4:0] reserved_bits;
		hyst_sel_t  hysteresis_select;
		logic       sensor_halt;
		logic       critical_limit_lock;
		logic       window_limits_lock;
		logic       alarm_release;
		logic       alarm_pin_state;
		logic       alarm_output_enable;
		logic       critical_only_select;
		logic       alarm_polarity;
		logic       alarm_mode_select;
	} cfg_t;

	typedef struct packed {
		logic signed [TEMP_W-1:0] upper;
		logic signed [TEMP_W-1:0] lower;
		logic signed [TEMP_W-1:0] crit;
	} limits_t;

	typedef struct packed {
		logic above_upper;
		logic below_lower;
		logic above_crit;
	} trips_t;

endpackage

// file: design/temp_sensor_config_event_ctrl.sv
// How it works
// - Configuration is a 16-bit read/write register at pointer 01h.
// - Hysteresis field bits 10:9 selects 0, 1.5, 3.0 or 6.0 degrees for all limits.
// - Hysteresis acts on falling temperature only; upper and critical alarms clear below limit minus it, lower alarm sets below limit minus it.
// - Upper-limit flag sets above limit, holds until below limit minus hysteresis.
// - Alarm pin uses the same hysteresis as the status flags.
// - Hysteresis writes ignored while either lock is set.
// - Halt bit 8 stops sampling, raises no alarms, releases the alarm pin.
// - Halt cannot be set while locked; clearing always allowed.
// - Register access keeps working while halted.
// - Bit 7 locks critical limit; only power-on reset clears it.
// - Bit 6 locks upper and lower limits; only power-on reset clears it.
// - Release bit 5 clears latched alarm in interrupt mode; reads as zero.
// - Bit 4 reads one while the alarm output is asserted.
// - Bit 3 enables alarm output; frozen while either lock set.
// - Bit 2 picks all limits or critical limit only for the alarm.
// - Critical-only bit frozen by window lock only.
// - Bit 1 sets pin polarity, low by default; frozen while locked.
// - Bit 0 picks comparator or interrupt mode; frozen while locked.
`timescale 1ns/1ps
module temp_sensor_config_event_ctrl
	import temp_cfg_pkg::*;
#(
	parameter int TW = TEMP_W
) (
	input  logic                 i_clk,
	input  logic                 i_rst_n,
	input  logic                 i_ptr_wr_en,
	input  logic [7:0]           i_ptr_data,
	input  logic                 i_reg_wr_en,
	input  logic [REG_W-1:0]     i_reg_wdata,
	input  logic                 i_reg_rd_en,
	input  logic                 i_temp_valid,
	input  logic signed [TW-1:0] i_temp,
	input  limits_t              i_limits,
	output logic                 o_cfg_selected,
	output logic [REG_W-1:0]     o_reg_rdata,
	output logic                 o_reg_rd_valid,
	output logic                 o_sensor_halt,
	output logic                 o_crit_lock,
	output logic                 o_window_lock,
	output logic signed [TW-1:0] o_temp,
	output trips_t               o_trips,
	output logic                 o_alarm_o,
	output logic                 o_alarm_oe
);

	logic [7:0]           ptr_q;
	logic                 cfg_wr;
	logic                 any_lock;
	hyst_sel_t            hyst_q;
	logic                 halt_q;
	logic                 crit_lock_q;
	logic                 win_lock_q;
	logic                 out_en_q;
	logic                 crit_only_q;
	logic                 pol_q;
	logic                 mode_q;
	logic                 release_wr;
	logic [HYST_W-1:0]    hyst_steps;
	logic                 sample;
	logic signed [TW-1:0] temp_q;
	logic [LIM_N-1:0]     trip;
	logic                 cond;
	logic                 cond_q;
	logic                 latch_q;
	logic                 assert_d;
	logic                 assert_q;
	logic                 level_q;
	logic                 oe_q;
	cfg_t                 view;
	logic [REG_W-1:0]     rdata_q;
	logic                 rd_valid_q;

	// Pointer selects the register; reset leaves it on the capability slot
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_q <= PTR_RESET;
		end else if (i_ptr_wr_en) begin
			ptr_q <= i_ptr_data;
		end
	end

	// Halt does not gate the register path
	assign o_cfg_selected = (ptr_q == CFG_PTR);
	assign cfg_wr         = i_reg_wr_en && o_cfg_selected;
	assign any_lock       = crit_lock_q || win_lock_q;
	assign release_wr     = cfg_wr && i_reg_wdata[CFG_REL_BIT] && mode_q;

	// Locks are judged before the write lands, so one write can set a lock and still change these fields
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hyst_q <= hyst_sel_t'(CFG_RESET[CFG_HYST_MSB:CFG_HYST_LSB]);
		end else if (cfg_wr && !any_lock) begin
			hyst_q <= hyst_sel_t'(i_reg_wdata[CFG_HYST_MSB:CFG_HYST_LSB]);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			halt_q <= CFG_RESET[CFG_HALT_BIT];
		end else if (cfg_wr) begin
			if (!i_reg_wdata[CFG_HALT_BIT]) begin
				halt_q <= 1'b0;
			end else if (!any_lock) begin
				halt_q <= 1'b1;
			end
		end
	end

	// Only the power-on reset can drop the locks
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crit_lock_q <= CFG_RESET[CFG_CLCK_BIT];
			win_lock_q  <= CFG_RESET[CFG_WLCK_BIT];
		end else if (cfg_wr) begin
			crit_lock_q <= crit_lock_q || i_reg_wdata[CFG_CLCK_BIT];
			win_lock_q  <= win_lock_q || i_reg_wdata[CFG_WLCK_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_en_q <= CFG_RESET[CFG_OEN_BIT];
			pol_q    <= CFG_RESET[CFG_POL_BIT];
			mode_q   <= CFG_RESET[CFG_MODE_BIT];
		end else if (cfg_wr && !any_lock) begin
			out_en_q <= i_reg_wdata[CFG_OEN_BIT];
			pol_q    <= i_reg_wdata[CFG_POL_BIT];
			mode_q   <= i_reg_wdata[CFG_MODE_BIT];
		end
	end

	// Critical lock deliberately leaves this bit writable
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crit_only_q <= CFG_RESET[CFG_CRIT_BIT];
		end else if (cfg_wr && !win_lock_q) begin
			crit_only_q <= i_reg_wdata[CFG_CRIT_BIT];
		end
	end

	always_comb begin
		case (hyst_q)
			HYST_NONE: hyst_steps = '0;
			HYST_1P5:  hyst_steps = HYST_1P5_STEPS;
			HYST_3P0:  hyst_steps = HYST_3P0_STEPS;
			HYST_6P0:  hyst_steps = HYST_6P0_STEPS;
			default:   hyst_steps = '0;
		endcase
	end

	// Halted sensor neither stores nor compares
	assign sample = i_temp_valid && !halt_q;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_q <= '0;
		end else if (sample) begin
			temp_q <= i_temp;
		end
	end

	for (genvar g = 0; g < LIM_N; g++) begin : g_lim
		limit_comparator #(
			.TRIP_BELOW (g == LIM_LOWER),
			.W          (TW)
		) u_cmp (
			.i_clk   (i_clk),
			.i_rst_n (i_rst_n),
			.i_sample(sample),
			.i_temp  (i_temp),
			.i_limit (g == LIM_UPPER ? i_limits.upper :
				(g == LIM_LOWER ? i_limits.lower : i_limits.crit)),
			.i_hyst  (hyst_steps),
			.o_trip  (trip[g])
		);
	end

	assign o_trips.above_upper = trip[LIM_UPPER];
	assign o_trips.below_lower = trip[LIM_LOWER];
	assign o_trips.above_crit  = trip[LIM_CRIT];

	// Pin condition built from the same hysteretic flags
	assign cond = crit_only_q ? trip[LIM_CRIT] : (|trip);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= cond;
		end
	end

	// New event wins over a release in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_q <= 1'b0;
		end else if (!mode_q) begin
			latch_q <= 1'b0;
		end else if (cond && !cond_q && !halt_q) begin
			latch_q <= 1'b1;
		end else if (release_wr) begin
			latch_q <= 1'b0;
		end
	end

	assign assert_d = out_en_q && !halt_q && (mode_q ? latch_q : cond);

	// Open drain: only the low level is driven, high needs the pull-up
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			assert_q <= 1'b0;
			level_q  <= 1'b1;
			oe_q     <= 1'b0;
		end else begin
			assert_q <= assert_d;
			level_q  <= assert_d ? pol_q : !pol_q;
			oe_q     <= out_en_q && !halt_q && !(assert_d ? pol_q : !pol_q);
		end
	end

	always_comb begin
		view                      = '0;
		view.hysteresis_select    = hyst_q;
		view.sensor_halt          = halt_q;
		view.critical_limit_lock  = crit_lock_q;
		view.window_limits_lock   = win_lock_q;
		view.alarm_release        = 1'b0;
		view.alarm_pin_state      = assert_q;
		view.alarm_output_enable  = out_en_q;
		view.critical_only_select = crit_only_q;
		view.alarm_polarity       = pol_q;
		view.alarm_mode_select    = mode_q;
	end

	// Other pointers read zero here; their registers live elsewhere
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q    <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= i_reg_rd_en;
			if (i_reg_rd_en) begin
				rdata_q <= o_cfg_selected ? view : '0;
			end
		end
	end

	assign o_reg_rdata    = rdata_q;
	assign o_reg_rd_valid = rd_valid_q;
	assign o_sensor_halt  = halt_q;
	assign o_crit_lock    = crit_lock_q;
	assign o_window_lock  = win_lock_q;
	assign o_temp         = temp_q;
	assign o_alarm_o      = level_q;
	assign o_alarm_oe     = oe_q;

	property p_rd_reserved;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_reg_rd_en && o_cfg_selected) |=>
			(rdata_q[CFG_RSVD_MSB:CFG_RSVD_LSB] == 5'h00) && !rdata_q[CFG_REL_BIT];
	endproperty
	a_rd_reserved: assert property (p_rd_reserved)
		else $error("reserved or release bit read nonzero");

	property p_crit_lock_sticky;
		@(posedge i_clk) disable iff (!i_rst_n)
		crit_lock_q |=> crit_lock_q;
	endproperty
	a_crit_lock_sticky: assert property (p_crit_lock_sticky)
		else $error("critical lock dropped without reset");

	property p_win_lock_sticky;
		@(posedge i_clk) disable iff (!i_rst_n)
		win_lock_q |=> win_lock_q;
	endproperty
	a_win_lock_sticky: assert property (p_win_lock_sticky)
		else $error("window lock dropped without reset");

	property p_halt_refused;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_wr && any_lock && !halt_q) |=> !halt_q;
	endproperty
	a_halt_refused: assert property (p_halt_refused)
		else $error("halt set while locked");

	property p_halt_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_wr && !i_reg_wdata[CFG_HALT_BIT]) |=> !halt_q;
	endproperty
	a_halt_clear: assert property (p_halt_clear)
		else $error("halt clear refused");

	property p_hyst_locked;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_wr && any_lock) |=> $stable(hyst_q);
	endproperty
	a_hyst_locked: assert property (p_hyst_locked)
		else $error("hysteresis changed while locked");

	property p_ctrl_locked;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_wr && any_lock) |=> $stable(out_en_q) && $stable(pol_q) && $stable(mode_q);
	endproperty
	a_ctrl_locked: assert property (p_ctrl_locked)
		else $error("alarm control changed while locked");

	property p_crit_only_locked;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cfg_wr && win_lock_q) |=> $stable(crit_only_q);
	endproperty
	a_crit_only_locked: assert property (p_crit_only_locked)
		else $error("critical-only changed under window lock");

	property p_halt_pin_free;
		@(posedge i_clk) disable iff (!i_rst_n)
		halt_q |=> !oe_q && !assert_q;
	endproperty
	a_halt_pin_free: assert property (p_halt_pin_free)
		else $error("alarm pin driven while halted");

	property p_latch_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		(mode_q && latch_q && !release_wr && !cfg_wr) |=> latch_q;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("interrupt alarm dropped without release");

	property p_pin_polarity;
		@(posedge i_clk) disable iff (!i_rst_n)
		assert_q |-> (level_q == $past(pol_q));
	endproperty
	a_pin_polarity: assert property (p_pin_polarity)
		else $error("alarm level does not follow polarity");

endmodule

// file: sim/host_line_model.sv
`timescale 1ns/1ps
// Far side of the alarm line: open-drain wire with its pull-up
module host_line_model (
	input  wire logic i_alarm_o,
	input  wire logic i_alarm_oe,
	output logic      o_pin
);
	// Released line floats up, never keeps the last driven level
	assign o_pin = i_alarm_oe ? i_alarm_o : 1'b1;
endmodule

// file: sim/temp_sensor_config_event_ctrl_bench.sv
`timescale 1ns/1ps
module temp_sensor_config_event_ctrl_bench
	import temp_cfg_pkg::*;
;
	logic                     clk = 1'b0;
	logic                     rst_n = 1'b0;
	logic                     ptr_wr_en = 1'b0;
	logic [7:0]               ptr_data = 8'h00;
	logic                     reg_wr_en = 1'b0;
	logic [REG_W-1:0]         reg_wdata = 16'h0000;
	logic                     reg_rd_en = 1'b0;
	logic                     temp_valid = 1'b0;
	logic signed [TEMP_W-1:0] temp = 13'sh0050;
	limits_t                  lim;
	logic                     cfg_sel;
	logic [REG_W-1:0]         rdata;
	logic                     rd_valid;
	logic                     halt;
	logic                     crit_lock;
	logic                     win_lock;
	logic signed [TEMP_W-1:0] temp_q;
	trips_t                   trips;
	logic                     alarm_o;
	logic                     alarm_oe;
	logic                     pin;
	int                       n_mismatch = 0;
	int                       check_count = 0;

	initial lim = '{upper: 13'sd400, lower: -13'sd80, crit: 13'sd600};
	always #2.5 clk = ~clk;

	temp_sensor_config_event_ctrl dut (
		.i_clk          (clk),
		.i_rst_n        (rst_n),
		.i_ptr_wr_en    (ptr_wr_en),
		.i_ptr_data     (ptr_data),
		.i_reg_wr_en    (reg_wr_en),
		.i_reg_wdata    (reg_wdata),
		.i_reg_rd_en    (reg_rd_en),
		.i_temp_valid   (temp_valid),
		.i_temp         (temp),
		.i_limits       (lim),
		.o_cfg_selected (cfg_sel),
		.o_reg_rdata    (rdata),
		.o_reg_rd_valid (rd_valid),
		.o_sensor_halt  (halt),
		.o_crit_lock    (crit_lock),
		.o_window_lock  (win_lock),
		.o_temp         (temp_q),
		.o_trips        (trips),
		.o_alarm_o      (alarm_o),
		.o_alarm_oe     (alarm_oe)
	);

	host_line_model line (
		.i_alarm_o  (alarm_o),
		.i_alarm_oe (alarm_oe),
		.o_pin      (pin)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic do_reset(input logic [7:0] p);
		rst_n = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		ptr_wr_en = 1'b1;
		ptr_data  = p;
		@(negedge clk);
		ptr_wr_en = 1'b0;
	endtask

	task automatic cfg_wr(input logic [15:0] d);
		@(negedge clk);
		reg_wr_en = 1'b1;
		reg_wdata = d;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask

	task automatic cfg_rd(input logic [15:0] exp);
		@(negedge clk);
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		check("rd_valid", 16'(rd_valid), 16'h0001);
		check("config", rdata, exp);
	endtask

	// Two edges: trips land on the first, the pin on the second in comparator mode (interrupt mode needs a third)
	task automatic sample(input logic signed [TEMP_W-1:0] t);
		@(negedge clk);
		temp       = t;
		temp_valid = 1'b1;
		@(negedge clk);
		temp_valid = 1'b0;
		@(negedge clk);
	endtask

	task automatic pin_is(input logic e);
		check("alarm_pin", 16'(pin), 16'(e));
	endtask

	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		do_reset(8'h00);
		check("cfg_selected", 16'(cfg_sel), 16'h0000);
		cfg_rd(16'h0000);
		do_reset(CFG_PTR);
		check("cfg_selected", 16'(cfg_sel), 16'h0001);
		cfg_rd(CFG_RESET);
		pin_is(1'b1);
		cfg_wr(16'hfe3f);
		cfg_rd(16'h060f);
		cfg_wr(16'h0000);
		$display("test reset_and_fields done");
		cfg_wr(16'h0108);
		sample(13'sd500);
		check("halt", 16'(halt), 16'h0001);
		check("temp", 16'(temp_q), 16'h0000);
		check("trips", 16'(trips), 16'h0000);
		pin_is(1'b1);
		check("alarm_oe", 16'(alarm_oe), 16'h0000);
		cfg_rd(16'h0108);
		cfg_wr(16'h0008);
		sample(13'sd500);
		check("temp", 16'(temp_q), 16'd500);
		pin_is(1'b0);
		cfg_rd(16'h0018);
		$display("test halt done");
		cfg_wr(16'h0208);
		sample(13'sd390);
		check("upper_trip", 16'(trips.above_upper), 16'h0001);
		pin_is(1'b0);
		sample(13'sd387);
		check("upper_trip", 16'(trips.above_upper), 16'h0000);
		pin_is(1'b1);
		cfg_wr(16'h0608);
		sample(13'sd500);
		sample(13'sd353);
		check("upper_trip", 16'(trips.above_upper), 16'h0001);
		sample(13'sd351);
		check("upper_trip", 16'(trips.above_upper), 16'h0000);
		sample(-13'sd120);
		check("lower_trip", 16'(trips.below_lower), 16'h0000);
		sample(-13'sd129);
		check("lower_trip", 16'(trips.below_lower), 16'h0001);
		cfg_wr(16'h0408);
		sample(13'sd500);
		sample(13'sd376);
		check("upper_trip", 16'(trips.above_upper), 16'h0001);
		sample(13'sd375);
		check("upper_trip", 16'(trips.above_upper), 16'h0000);
		$display("test hysteresis done");
		cfg_wr(16'h000c);
		sample(13'sd500);
		pin_is(1'b1);
		sample(13'sd700);
		check("crit_trip", 16'(trips.above_crit), 16'h0001);
		pin_is(1'b0);
		sample(-13'sd100);
		check("lower_trip", 16'(trips.below_lower), 16'h0001);
		pin_is(1'b1);
		cfg_wr(16'h0008);
		sample(-13'sd100);
		pin_is(1'b0);
		sample(13'sd80);
		$display("test critical_only done");
		cfg_wr(16'h0009);
		sample(13'sd500);
		sample(13'sd80);
		pin_is(1'b0);
		cfg_wr(16'h0029);
		@(negedge clk);
		pin_is(1'b1);
		cfg_wr(16'h0008);
		sample(13'sd500);
		cfg_wr(16'h0028);
		@(negedge clk);
		pin_is(1'b0);
		cfg_wr(16'h000a);
		sample(13'sd500);
		pin_is(1'b1);
		sample(13'sd80);
		pin_is(1'b0);
		$display("test alarm_modes done");
		cfg_wr(16'h00c0);
		cfg_wr(16'h073f);
		cfg_rd(16'h00c0);
		check("locks", {14'h0, crit_lock, win_lock}, 16'h0003);
		do_reset(CFG_PTR);
		check("locks", {14'h0, crit_lock, win_lock}, 16'h0000);
		cfg_wr(16'h0100);
		cfg_wr(16'h0180);
		cfg_rd(16'h0180);
		cfg_wr(16'h0084);
		cfg_rd(16'h0084);
		cfg_wr(16'h0100);
		cfg_rd(16'h0080);
		do_reset(CFG_PTR);
		cfg_wr(16'h0040);
		cfg_wr(16'h0004);
		cfg_rd(16'h0040);
		$display("test locks done");
		tally_and_finish();
	end
endmodule
